/* File: inc/xbp_pkg.sv */
/*
  xbp_pkg: shared constants and channel carriers for one crossbar slot path.
  assumes a single clock domain and a 32-bit native data width.
*/
package xbp_pkg;

  // native data width and datapath fifo depth
  localparam int DATA_W = 32;
  localparam int FIFO_DEPTH = 16;
  localparam int FIFO_LVL_W = 5;

  // channel slots; slices 0..4 face the master, 5..9 the slave
  localparam int CH_AW = 0;
  localparam int CH_W = 1;
  localparam int CH_B = 2;
  localparam int CH_AR = 3;
  localparam int CH_R = 4;
  localparam int NCH = 5;

  // slice styles held in the two-bit select fields
  localparam logic [1:0] SL_BYPASS = 2'h0;
  localparam logic [1:0] SL_SINGLE = 2'h1;
  localparam logic [1:0] SL_TWO = 2'h2;
  localparam logic [1:0] SL_AUTO = 2'h3;

  // response codes and protection bit position
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;
  localparam int PROT_NS_BIT = 1;

  // register port map
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_STAT = 4'h4;
  localparam logic [31:0] CTRL_RST = 32'h0000_0003;
  localparam logic [31:0] CTRL_WMASK = 32'h0fff_ffff;
  localparam int STAT_WST_LSB = 0;
  localparam int STAT_RST_LSB = 4;
  localparam int STAT_WLVL_LSB = 8;
  localparam int STAT_RLVL_LSB = 16;
  localparam int STAT_ERR_LSB = 24;

  typedef struct packed {
    logic [31:0] addr;
    logic [7:0] len;
    logic [2:0] size;
    logic [3:0] cache;
    logic [2:0] prot;
  } xbp_addr_s;

  typedef struct packed {
    logic [DATA_W-1:0] data;
    logic [3:0] strb;
    logic last;
  } xbp_wdat_s;

  typedef struct packed {
    logic [1:0] resp;
  } xbp_bres_s;

  typedef struct packed {
    logic [DATA_W-1:0] data;
    logic [1:0] resp;
    logic last;
  } xbp_rdat_s;

  // control register layout
  typedef struct packed {
    logic [3:0] spare;
    logic [9:0] mi_sel;
    logic [9:0] si_sel;
    logic mi_narrow_ok;
    logic si_narrow_ok;
    logic rfifo_en;
    logic wfifo_en;
    logic lite;
    logic secure;
    logic rd_en;
    logic wr_en;
  } xbp_ctrl_s;

  localparam int AD_W = $bits(xbp_addr_s);
  localparam int WD_W = $bits(xbp_wdat_s);
  localparam int BR_W = $bits(xbp_bres_s);
  localparam int RD_W = $bits(xbp_rdat_s);
  localparam int CW = AD_W;

endpackage

/* File: src/xbp_slot_path.sv */
/*
  slot path of a crossbar: per-channel register slices on both sides,
  read/write pathway gating, secure-slot decode errors, data fifos.
  assumes one clock, synchronous inputs, config changed only when idle.
*/
// The placing of the registers and strobed register access were chosen for this implementation.
`timescale 1ns/1ps

// generic fifo, one word per entry, depth a power of two
module xbp_fifo
  import xbp_pkg::*;
#(
  parameter int W = 8,
  parameter int DEPTH = 16
)(
  input wire logic clock, // system clock
  input wire logic nrst, // async reset, low
  input wire logic [W-1:0] in_data, // write word
  input wire logic in_valid, // word offered
  output logic in_ready, // room left
  output logic [W-1:0] out_data, // head word
  output logic out_valid, // not empty
  input wire logic out_ready, // head taken
  output logic [$clog2(DEPTH):0] level // words held
);
  localparam int AW = $clog2(DEPTH);
  logic [W-1:0] mem [DEPTH];
  logic [AW-1:0] wp_r, rp_r;
  logic [AW:0] cnt_r;
  wire push = in_valid & in_ready;
  wire pop = out_valid & out_ready;

  // flags and head word
  assign in_ready = (cnt_r != (AW+1)'(DEPTH));
  assign out_valid = (cnt_r != '0);
  assign out_data = mem[rp_r];
  assign level = cnt_r;

  // storage
  always_ff @(posedge clock)
  begin
    if (push)
      mem[wp_r] <= in_data;
  end

  // pointers and fill count
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      wp_r <= '0;
      rp_r <= '0;
      cnt_r <= '0;
    end
    else
    begin
      if (push)
        wp_r <= wp_r + 1'h1;
      if (pop)
        rp_r <= rp_r + 1'h1;
      cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

  property p_full_stalls;
    @(posedge clock) disable iff (!nrst)
    (cnt_r == (AW+1)'(DEPTH)) |-> !in_ready ##1 (cnt_r != '0);
  endproperty
  a_full_stalls: assert property (p_full_stalls)
    else $error("fifo accepted while full");
endmodule

// register slice: bypass, single stage or two entry
module xbp_slice
  import xbp_pkg::*;
#(
  parameter int W = 8
)(
  input wire logic clock, // system clock
  input wire logic nrst, // async reset, low
  input wire logic [1:0] mode, // resolved style
  input wire logic [W-1:0] in_data, // source word
  input wire logic in_valid, // source valid
  output logic in_ready, // source ready
  output logic [W-1:0] out_data, // sink word
  output logic out_valid, // sink valid
  input wire logic out_ready // sink ready
);
  logic [W-1:0] m_d_r, s_d_r;
  logic m_v_r, s_v_r;
  wire byp = (mode == SL_BYPASS);
  wire two = (mode == SL_TWO);
  wire take = in_valid & in_ready;
  wire give = m_v_r & out_ready;

  // single stage refuses while full, hence one idle cycle per word
  assign in_ready = byp ? out_ready : (two ? ~s_v_r : ~m_v_r);
  assign out_valid = byp ? in_valid : m_v_r;
  assign out_data = byp ? in_data : m_d_r;

  // main entry refills from skid entry first, keeping order
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      m_v_r <= 1'h0;
      s_v_r <= 1'h0;
      m_d_r <= '0;
      s_d_r <= '0;
    end
    else if (byp)
    begin
      m_v_r <= 1'h0;
      s_v_r <= 1'h0;
    end
    else if (give | ~m_v_r)
    begin
      m_v_r <= s_v_r | take;
      m_d_r <= s_v_r ? s_d_r : in_data;
      s_v_r <= 1'h0;
    end
    else if (take)
    begin
      s_v_r <= 1'h1;
      s_d_r <= in_data;
    end
  end

  property p_one_cycle;
    @(posedge clock) disable iff (!nrst)
    (!byp && take && !m_v_r) |=> (out_valid && out_data == $past(in_data));
  endproperty
  a_one_cycle: assert property (p_one_cycle)
    else $error("slice latency not one cycle");

  property p_no_gap;
    @(posedge clock) disable iff (!nrst)
    (two && give && (in_valid || s_v_r)) |=> out_valid;
  endproperty
  a_no_gap: assert property (p_no_gap)
    else $error("two entry slice left a gap");

  property p_bubble;
    @(posedge clock) disable iff (!nrst)
    (mode == SL_SINGLE && give) |=> !out_valid;
  endproperty
  a_bubble: assert property (p_bubble)
    else $error("single stage slice gave no idle cycle");
endmodule

// Contract
// - write disabled removes address, data and response write paths.
// - read disabled removes read address and read data paths.
// - each slot keeps write, read, or both enabled; never neither.
// - optional slice per channel per slot, adding one cycle.
// - two entry slice absorbs stalls, passes back to back.
// - single stage slice idles one cycle after each transfer.
// - auto picks single for lite; else two on data, single elsewhere.
// - nonzero fifo setting puts a fifo on data beside the core.
// - fifo words are native data width.
// - secure slave slot accepts only protection bit 1 low.
// - non-secure access to secure slot is dropped and answered.
// - narrow bursts are not checked nor answered with error.
// - upsizers pack fully, never creating narrow bursts.
// - slave-side narrow flag is informative only.
// - decode errors return the decode error response code.
module xbp_slot_path
  import xbp_pkg::*;
(
  input wire logic clock, // 100 mhz clock
  input wire logic nrst, // async reset, low
  input wire logic [3:0] reg_addr, // register byte address
  input wire logic [31:0] reg_wdata, // register write data
  input wire logic reg_wr, // write strobe
  input wire logic reg_rd, // read strobe
  output logic [31:0] reg_rdata, // read data, next cycle
  input wire xbp_addr_s si_aw, // master write address
  input wire logic si_aw_valid, // master aw valid
  output logic si_aw_ready, // master aw ready
  input wire xbp_wdat_s si_w, // master write data
  input wire logic si_w_valid, // master w valid
  output logic si_w_ready, // master w ready
  output xbp_bres_s si_b, // master write response
  output logic si_b_valid, // master b valid
  input wire logic si_b_ready, // master b ready
  input wire xbp_addr_s si_ar, // master read address
  input wire logic si_ar_valid, // master ar valid
  output logic si_ar_ready, // master ar ready
  output xbp_rdat_s si_r, // master read data
  output logic si_r_valid, // master r valid
  input wire logic si_r_ready, // master r ready
  output xbp_addr_s mi_aw, // slave write address
  output logic mi_aw_valid, // slave aw valid
  input wire logic mi_aw_ready, // slave aw ready
  output xbp_wdat_s mi_w, // slave write data
  output logic mi_w_valid, // slave w valid
  input wire logic mi_w_ready, // slave w ready
  input wire xbp_bres_s mi_b, // slave write response
  input wire logic mi_b_valid, // slave b valid
  output logic mi_b_ready, // slave b ready
  output xbp_addr_s mi_ar, // slave read address
  output logic mi_ar_valid, // slave ar valid
  input wire logic mi_ar_ready, // slave ar ready
  input wire xbp_rdat_s mi_r, // slave read data
  input wire logic mi_r_valid, // slave r valid
  output logic mi_r_ready // slave r ready
);
  typedef enum logic [3:0] {
    W_IDLE = 4'h1, W_PASS = 4'h2, W_EDATA = 4'h4, W_ERESP = 4'h8
  } xbp_wst_e;
  typedef enum logic [2:0] {
    R_IDLE = 3'h1, R_PASS = 3'h2, R_ERR = 3'h4
  } xbp_rst_e;

  xbp_ctrl_s ctrl_r;
  xbp_wst_e wst_r, wst_nxt;
  xbp_rst_e rdst_r, rdst_nxt;
  logic [7:0] rcnt_r, errs_r;
  logic [31:0] reg_rdata_r;
  logic [CW-1:0] sl_in_d [2*NCH];
  logic [CW-1:0] sl_out_d [2*NCH];
  logic [1:0] sl_mode [2*NCH];
  logic [2*NCH-1:0] sl_in_v, sl_in_r, sl_out_v, sl_out_r;
  logic [WD_W-1:0] wf_out_d;
  logic [RD_W-1:0] rf_out_d;
  logic wf_in_r, wf_out_v, rf_in_r, rf_out_v;
  logic [FIFO_LVL_W-1:0] wf_lvl, rf_lvl;

  // slices: index below NCH faces the master, the rest the slave
  wire [19:0] all_sel = {ctrl_r.mi_sel, ctrl_r.si_sel};
  for (genvar k = 0; k < 2*NCH; k++)
  begin : g_slice
    localparam int C = k % NCH;
    wire [1:0] sel = all_sel[2*k +: 2];
    wire data_ch = (C == CH_W) || (C == CH_R);
    wire [1:0] auto_m = (!ctrl_r.lite && data_ch) ? SL_TWO : SL_SINGLE;
    assign sl_mode[k] = (sel == SL_AUTO) ? auto_m : sel;
    xbp_slice #(.W(CW)) u_sl (
      .clock(clock),
      .nrst(nrst),
      .mode(sl_mode[k]),
      .in_data(sl_in_d[k]),
      .in_valid(sl_in_v[k]),
      .in_ready(sl_in_r[k]),
      .out_data(sl_out_d[k]),
      .out_valid(sl_out_v[k]),
      .out_ready(sl_out_r[k])
    );
  end

  // port side of the outer slices
  assign sl_in_d[CH_AW] = CW'(si_aw);
  assign sl_in_v[CH_AW] = si_aw_valid & ctrl_r.wr_en;
  assign si_aw_ready = sl_in_r[CH_AW] & ctrl_r.wr_en;
  assign sl_in_d[CH_W] = CW'(si_w);
  assign sl_in_v[CH_W] = si_w_valid & ctrl_r.wr_en;
  assign si_w_ready = sl_in_r[CH_W] & ctrl_r.wr_en;
  assign si_b = sl_out_d[CH_B][BR_W-1:0];
  assign si_b_valid = sl_out_v[CH_B];
  assign sl_out_r[CH_B] = si_b_ready;
  assign sl_in_d[CH_AR] = CW'(si_ar);
  assign sl_in_v[CH_AR] = si_ar_valid & ctrl_r.rd_en;
  assign si_ar_ready = sl_in_r[CH_AR] & ctrl_r.rd_en;
  assign si_r = sl_out_d[CH_R][RD_W-1:0];
  assign si_r_valid = sl_out_v[CH_R];
  assign sl_out_r[CH_R] = si_r_ready;
  assign mi_aw = sl_out_d[NCH+CH_AW][AD_W-1:0];
  assign mi_aw_valid = sl_out_v[NCH+CH_AW];
  assign sl_out_r[NCH+CH_AW] = mi_aw_ready;
  assign mi_w = sl_out_d[NCH+CH_W][WD_W-1:0];
  assign mi_w_valid = sl_out_v[NCH+CH_W];
  assign sl_out_r[NCH+CH_W] = mi_w_ready;
  assign sl_in_d[NCH+CH_B] = CW'(mi_b);
  assign sl_in_v[NCH+CH_B] = mi_b_valid & ctrl_r.wr_en;
  assign mi_b_ready = sl_in_r[NCH+CH_B] & ctrl_r.wr_en;
  assign mi_ar = sl_out_d[NCH+CH_AR][AD_W-1:0];
  assign mi_ar_valid = sl_out_v[NCH+CH_AR];
  assign sl_out_r[NCH+CH_AR] = mi_ar_ready;
  assign sl_in_d[NCH+CH_R] = CW'(mi_r);
  assign sl_in_v[NCH+CH_R] = mi_r_valid & ctrl_r.rd_en;
  assign mi_r_ready = sl_in_r[NCH+CH_R] & ctrl_r.rd_en;

  // write side decode; narrow bursts pass unchecked
  xbp_addr_s aw_in, ar_in;
  assign aw_in = sl_out_d[CH_AW][AD_W-1:0];
  wire w_idle = (wst_r == W_IDLE);
  wire w_pass = (wst_r == W_PASS);
  wire w_edata = (wst_r == W_EDATA);
  wire w_eresp = (wst_r == W_ERESP);
  wire aw_bad = ctrl_r.secure & aw_in.prot[PROT_NS_BIT];
  wire aw_open = w_idle & ctrl_r.wr_en;
  assign sl_in_d[NCH+CH_AW] = sl_out_d[CH_AW];
  assign sl_in_v[NCH+CH_AW] = aw_open & sl_out_v[CH_AW] & ~aw_bad;
  assign sl_out_r[CH_AW] = aw_open & (aw_bad | sl_in_r[NCH+CH_AW]);
  wire aw_take = sl_out_v[CH_AW] & sl_out_r[CH_AW];

  // write data, optionally through the fifo; error beats are sunk
  wire [WD_W-1:0] w_vec = sl_out_d[CH_W][WD_W-1:0];
  wire wf_in_v = w_pass & ctrl_r.wfifo_en & sl_out_v[CH_W];
  wire w_thru_r = ctrl_r.wfifo_en ? wf_in_r : sl_in_r[NCH+CH_W];
  assign sl_out_r[CH_W] = w_edata | (w_pass & w_thru_r);
  wire [WD_W-1:0] w_fwd = ctrl_r.wfifo_en ? wf_out_d : w_vec;
  assign sl_in_d[NCH+CH_W] = CW'(w_fwd);
  assign sl_in_v[NCH+CH_W] = ctrl_r.wfifo_en ? wf_out_v
                                             : (w_pass & sl_out_v[CH_W]);
  wire w_end = sl_out_v[CH_W] & w_vec[0];

  // write response: slave answer or decode error
  wire [BR_W-1:0] b_fwd = w_eresp ? RESP_DECERR
                                  : sl_out_d[NCH+CH_B][BR_W-1:0];
  assign sl_in_d[CH_B] = CW'(b_fwd);
  assign sl_in_v[CH_B] = w_eresp | (w_pass & sl_out_v[NCH+CH_B]);
  assign sl_out_r[NCH+CH_B] = w_pass & sl_in_r[CH_B];
  wire b_take = sl_in_v[CH_B] & sl_in_r[CH_B];

  // write sequencer, one transaction at a time
  always_comb
  begin
    wst_nxt = wst_r;
    case (wst_r)
      W_IDLE: if (aw_take) wst_nxt = aw_bad ? W_EDATA : W_PASS;
      W_PASS: if (b_take) wst_nxt = W_IDLE;
      W_EDATA: if (w_end) wst_nxt = W_ERESP;
      W_ERESP: if (b_take) wst_nxt = W_IDLE;
      default: wst_nxt = W_IDLE;
    endcase
  end

  // read side decode
  assign ar_in = sl_out_d[CH_AR][AD_W-1:0];
  wire r_idle = (rdst_r == R_IDLE);
  wire r_pass = (rdst_r == R_PASS);
  wire r_err = (rdst_r == R_ERR);
  wire ar_bad = ctrl_r.secure & ar_in.prot[PROT_NS_BIT];
  wire ar_open = r_idle & ctrl_r.rd_en;
  assign sl_in_d[NCH+CH_AR] = sl_out_d[CH_AR];
  assign sl_in_v[NCH+CH_AR] = ar_open & sl_out_v[CH_AR] & ~ar_bad;
  assign sl_out_r[CH_AR] = ar_open & (ar_bad | sl_in_r[NCH+CH_AR]);
  wire ar_take = sl_out_v[CH_AR] & sl_out_r[CH_AR];

  // read data through optional fifo, or decode-error beats
  wire [RD_W-1:0] r_mi = sl_out_d[NCH+CH_R][RD_W-1:0];
  wire rf_in_v = r_pass & ctrl_r.rfifo_en & sl_out_v[NCH+CH_R];
  wire r_thru_r = ctrl_r.rfifo_en ? rf_in_r : sl_in_r[CH_R];
  assign sl_out_r[NCH+CH_R] = r_pass & r_thru_r;
  wire [RD_W-1:0] r_fwd = ctrl_r.rfifo_en ? rf_out_d : r_mi;
  wire r_fwd_v = ctrl_r.rfifo_en ? rf_out_v : (r_pass & sl_out_v[NCH+CH_R]);
  wire [RD_W-1:0] r_errw = {32'h0, RESP_DECERR, rcnt_r == 8'h0};
  assign sl_in_d[CH_R] = CW'(r_err ? r_errw : r_fwd);
  assign sl_in_v[CH_R] = r_err | (~r_err & r_fwd_v);
  wire rf_out_r = ~r_err & sl_in_r[CH_R];
  wire r_take = sl_in_v[CH_R] & sl_in_r[CH_R];
  wire r_last = r_take & sl_in_d[CH_R][0];

  // read sequencer
  always_comb
  begin
    rdst_nxt = rdst_r;
    case (rdst_r)
      R_IDLE: if (ar_take) rdst_nxt = ar_bad ? R_ERR : R_PASS;
      R_PASS: if (r_last) rdst_nxt = R_IDLE;
      R_ERR: if (r_last) rdst_nxt = R_IDLE;
      default: rdst_nxt = R_IDLE;
    endcase
  end

  // data fifos hold full native words, width untouched
  xbp_fifo #(.W(WD_W), .DEPTH(FIFO_DEPTH)) u_wfifo (
    .clock(clock),
    .nrst(nrst),
    .in_data(w_vec),
    .in_valid(wf_in_v),
    .in_ready(wf_in_r),
    .out_data(wf_out_d),
    .out_valid(wf_out_v),
    .out_ready(sl_in_r[NCH+CH_W]),
    .level(wf_lvl)
  );
  xbp_fifo #(.W(RD_W), .DEPTH(FIFO_DEPTH)) u_rfifo (
    .clock(clock),
    .nrst(nrst),
    .in_data(r_mi),
    .in_valid(rf_in_v),
    .in_ready(rf_in_r),
    .out_data(rf_out_d),
    .out_valid(rf_out_v),
    .out_ready(rf_out_r),
    .level(rf_lvl)
  );

  // register decode; narrow flags are stored only, never acted on
  wire ctrl_ok = reg_wdata[0] | reg_wdata[1];
  wire ctrl_we = reg_wr & (reg_addr == REG_CTRL) & ctrl_ok;
  wire [31:0] stat_w = (32'(wst_r) << STAT_WST_LSB)
                     | (32'(rdst_r) << STAT_RST_LSB)
                     | (32'(wf_lvl) << STAT_WLVL_LSB)
                     | (32'(rf_lvl) << STAT_RLVL_LSB)
                     | (32'(errs_r) << STAT_ERR_LSB);
  wire [31:0] rd_mux = (reg_addr == REG_CTRL) ? 32'(ctrl_r)
                     : (reg_addr == REG_STAT) ? stat_w : 32'h0;
  assign reg_rdata = reg_rdata_r;

  // state, control and counters
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      ctrl_r <= CTRL_RST;
      wst_r <= W_IDLE;
      rdst_r <= R_IDLE;
      rcnt_r <= 8'h0;
      errs_r <= 8'h0;
      reg_rdata_r <= 32'h0;
    end
    else
    begin
      if (ctrl_we)
        ctrl_r <= reg_wdata & CTRL_WMASK;
      wst_r <= wst_nxt;
      rdst_r <= rdst_nxt;
      if (ar_take)
        rcnt_r <= ar_in.len;
      else if (r_err & r_take)
        rcnt_r <= rcnt_r - 8'h1;
      errs_r <= errs_r + 8'(aw_take & aw_bad) + 8'(ar_take & ar_bad);
      reg_rdata_r <= reg_rd ? rd_mux : 32'h0;
    end
  end

  property p_wr_off;
    @(posedge clock) disable iff (!nrst)
    (!ctrl_r.wr_en && w_idle) |-> !sl_in_v[NCH+CH_AW] && !si_aw_ready;
  endproperty
  a_wr_off: assert property (p_wr_off)
    else $error("write path active while disabled");

  property p_rd_off;
    @(posedge clock) disable iff (!nrst)
    (!ctrl_r.rd_en && r_idle) |-> !sl_in_v[NCH+CH_AR] && !sl_out_r[CH_AR];
  endproperty
  a_rd_off: assert property (p_rd_off)
    else $error("read path active while disabled");

  property p_one_dir;
    @(posedge clock) disable iff (!nrst)
    ctrl_we |=> (ctrl_r.wr_en || ctrl_r.rd_en) && $past(ctrl_ok);
  endproperty
  a_one_dir: assert property (p_one_dir)
    else $error("slot left with no direction");

  property p_auto;
    @(posedge clock) disable iff (!nrst)
    (ctrl_r.si_sel[3:2] == SL_AUTO) |->
      sl_mode[CH_W] == (ctrl_r.lite ? SL_SINGLE : SL_TWO);
  endproperty
  a_auto: assert property (p_auto)
    else $error("automatic style wrong on write data");

  property p_aw_block;
    @(posedge clock) disable iff (!nrst)
    (aw_take && aw_bad) |-> !sl_in_v[NCH+CH_AW] ##1 w_edata;
  endproperty
  a_aw_block: assert property (p_aw_block)
    else $error("non-secure write forwarded");

  property p_ar_secure;
    @(posedge clock) disable iff (!nrst)
    sl_in_v[NCH+CH_AR] && ctrl_r.secure |-> !ar_in.prot[PROT_NS_BIT];
  endproperty
  a_ar_secure: assert property (p_ar_secure)
    else $error("non-secure read reached secure slot");

  property p_b_decerr;
    @(posedge clock) disable iff (!nrst)
    (w_edata && w_end) |=> sl_in_v[CH_B] && b_fwd == RESP_DECERR;
  endproperty
  a_b_decerr: assert property (p_b_decerr)
    else $error("missing write decode error");

  property p_r_decerr;
    @(posedge clock) disable iff (!nrst)
    (ar_take && ar_bad) |=> r_err && sl_in_v[CH_R]
      && sl_in_d[CH_R][2:1] == RESP_DECERR;
  endproperty
  a_r_decerr: assert property (p_r_decerr)
    else $error("missing read decode error");
endmodule

/* File: verif/xbp_slave_model.sv */
/*
  slave device model facing the slave-side channels of the slot path.
  assumes one clock; one write and one read outstanding at a time.
*/
`timescale 1ns/1ps
module xbp_slave_model
  import xbp_pkg::*;
(
  input wire logic clock, // system clock
  input wire logic nrst, // async reset, low
  input wire logic stall, // hold write data back
  input wire xbp_addr_s mi_aw, // write address
  input wire logic mi_aw_valid, // aw valid
  output logic mi_aw_ready, // aw ready
  input wire xbp_wdat_s mi_w, // write data
  input wire logic mi_w_valid, // w valid
  output logic mi_w_ready, // w ready
  output xbp_bres_s mi_b, // write response
  output logic mi_b_valid, // b valid
  input wire logic mi_b_ready, // b ready
  input wire xbp_addr_s mi_ar, // read address
  input wire logic mi_ar_valid, // ar valid
  output logic mi_ar_ready, // ar ready
  output xbp_rdat_s mi_r, // read data
  output logic mi_r_valid, // r valid
  input wire logic mi_r_ready, // r ready
  output int aw_cnt, // addresses taken
  output logic [31:0] last_w // last data word taken
);
  logic [7:0] left;
  // one transfer of each kind in flight
  assign mi_aw_ready = !mi_b_valid;
  assign mi_w_ready = !stall;
  assign mi_ar_ready = !mi_r_valid;
  // responses; released lines keep changing
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      aw_cnt <= 0;
      last_w <= '0;
      mi_b <= '0;
      mi_b_valid <= 1'b0;
      mi_r <= '0;
      mi_r_valid <= 1'b0;
      left <= '0;
    end
    else
    begin
      if (mi_aw_valid && mi_aw_ready)
        aw_cnt <= aw_cnt + 1;
      if (mi_w_valid && mi_w_ready)
        last_w <= mi_w.data;
      if (mi_w_valid && mi_w_ready && mi_w.last)
      begin
        mi_b_valid <= 1'b1;
        mi_b <= '{RESP_OKAY};
      end
      else if (mi_b_valid && mi_b_ready)
      begin
        mi_b_valid <= 1'b0;
        mi_b <= ~mi_b;
      end
      if (mi_ar_valid && mi_ar_ready)
      begin
        mi_r_valid <= 1'b1;
        left <= mi_ar.len;
        mi_r <= '{mi_ar.addr, RESP_OKAY, mi_ar.len == 8'h0};
      end
      else if (mi_r_valid && mi_r_ready)
      begin
        mi_r_valid <= left != 8'h0;
        left <= left - 8'h1;
        mi_r <= '{mi_r.data + 32'h1, RESP_OKAY, left == 8'h1};
      end
    end
  end
endmodule

/* File: verif/xbp_slot_path_bench.sv */
/*
  self-checking bench for the slot path with a slave model behind it.
  assumes the package, slot path and slave model are compiled first.
*/
`timescale 1ns/1ps
module xbp_slot_path_bench
  import xbp_pkg::*;
;
  logic clock, nrst, reg_wr, reg_rd, stall;
  logic [3:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, last_w;
  xbp_addr_s si_aw, si_ar, mi_aw, mi_ar;
  xbp_wdat_s si_w, mi_w;
  xbp_bres_s si_b, mi_b;
  xbp_rdat_s si_r, mi_r;
  logic si_aw_valid, si_aw_ready, si_w_valid, si_w_ready, si_b_valid;
  logic si_ar_valid, si_ar_ready, si_r_valid, mi_aw_valid, mi_aw_ready;
  logic mi_w_valid, mi_w_ready, mi_b_valid, mi_b_ready, mi_ar_valid;
  logic mi_ar_ready, mi_r_valid, mi_r_ready;
  int fails, checks_done, aw_cnt;

  xbp_slot_path u_xbp_slot_path (
    .clock, .nrst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .si_aw, .si_aw_valid, .si_aw_ready, .si_w, .si_w_valid, .si_w_ready,
    .si_b, .si_b_valid, .si_b_ready(1'b1), .si_ar, .si_ar_valid,
    .si_ar_ready, .si_r, .si_r_valid, .si_r_ready(1'b1), .mi_aw,
    .mi_aw_valid, .mi_aw_ready, .mi_w, .mi_w_valid, .mi_w_ready, .mi_b,
    .mi_b_valid, .mi_b_ready, .mi_ar, .mi_ar_valid, .mi_ar_ready, .mi_r,
    .mi_r_valid, .mi_r_ready
  );
  xbp_slave_model u_xbp_slave_model (
    .clock, .nrst, .stall, .mi_aw, .mi_aw_valid, .mi_aw_ready, .mi_w,
    .mi_w_valid, .mi_w_ready, .mi_b, .mi_b_valid, .mi_b_ready, .mi_ar,
    .mi_ar_valid, .mi_ar_ready, .mi_r, .mi_r_valid, .mi_r_ready, .aw_cnt,
    .last_w
  );

  // clock
  initial
  begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks_done++;
    if (g !== e)
    begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  // register port cycles; a gap cycle after each write
  task automatic wreg(input logic [3:0] a, input logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
    @(posedge clock);
  endtask
  task automatic rreg(input logic [3:0] a, output logic [31:0] d);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clock);
    reg_rd <= 1'b0;
    @(negedge clock);
    d = reg_rdata;
    @(posedge clock);
  endtask
  task automatic cr(input logic [3:0] a, input logic [31:0] e);
    logic [31:0] d;
    rreg(a, d);
    chk(d, e);
  endtask

  // full write burst: span of data accepts, cycles to response
  task automatic wr(input logic [7:0] n, input logic [2:0] p,
    output logic [1:0] rs, output int sp, output int lt);
    time t0;
    si_aw <= '{32'h40, n, 3'h2, 4'h2, p};
    si_aw_valid <= 1'b1;
    do @(negedge clock); while (!si_aw_ready);
    @(posedge clock);
    si_aw_valid <= 1'b0;
    for (int i = 0; i <= n; i++)
    begin
      si_w <= '{32'ha0 + i, 4'hf, i == n};
      si_w_valid <= 1'b1;
      do @(negedge clock); while (!si_w_ready);
      @(posedge clock);
      if (i == 0)
        t0 = $time;
    end
    si_w_valid <= 1'b0;
    sp = ($time - t0) / 10;
    lt = 0;
    do
    begin
      @(negedge clock);
      lt++;
    end
    while (!si_b_valid);
    rs = si_b.resp;
    @(posedge clock);
  endtask

  // read burst: last response and beat count
  task automatic rda(input logic [7:0] n, input logic [2:0] p,
    output logic [1:0] rs, output int k);
    logic l;
    si_ar <= '{32'h80, n, 3'h2, 4'h2, p};
    si_ar_valid <= 1'b1;
    do @(negedge clock); while (!si_ar_ready);
    @(posedge clock);
    si_ar_valid <= 1'b0;
    k = 0;
    do
    begin
      do @(negedge clock); while (!si_r_valid);
      k++;
      rs = si_r.resp;
      l = si_r.last;
      @(posedge clock);
    end
    while (!l);
  endtask

  task automatic t_regs;
    cr(REG_CTRL, CTRL_RST);
    wreg(REG_CTRL, 32'hf0);
    cr(REG_CTRL, CTRL_RST);
    cr(4'h8, 32'h0);
  endtask

  // plain and secure slot accesses
  task automatic t_secure;
    logic [1:0] rs;
    int sp, lt, n;
    wr(8'h1, 3'h0, rs, sp, lt);
    chk(rs, RESP_OKAY);
    wreg(REG_CTRL, 32'h7);
    wr(8'h2, 3'h2, rs, sp, lt);
    chk({rs, aw_cnt[7:0]}, {RESP_DECERR, 8'h1});
    rda(8'h2, 3'h2, rs, n);
    chk({rs, n[7:0]}, {RESP_DECERR, 8'h3});
    wr(8'h0, 3'h0, rs, sp, lt);
    chk({rs, aw_cnt[7:0]}, {RESP_OKAY, 8'h2});
    rda(8'h1, 3'h0, rs, n);
    chk({rs, n[7:0]}, {RESP_OKAY, 8'h2});
  endtask

  // a request on a disabled direction sees no handshake
  task automatic quiet(input logic [31:0] ctl, input logic a);
    wreg(REG_CTRL, ctl);
    si_aw_valid <= a;
    si_ar_valid <= !a;
    repeat (6)
    begin
      @(negedge clock);
      chk(a ? {si_aw_ready, si_w_ready, mi_aw_valid, mi_b_ready}
        : {si_ar_ready, mi_ar_valid, mi_r_ready, 1'b0}, 32'h0);
      @(posedge clock);
    end
    si_aw_valid <= 1'b0;
    si_ar_valid <= 1'b0;
  endtask

  // data slice styles: accept span and response delay
  task automatic t_slice;
    logic [1:0] rs;
    int sp, lt;
    logic [31:0] ctl [5] = '{32'h3, 32'h803, 32'h403, 32'hc03, 32'hc0b};
    int esp [5] = '{3, 3, 6, 3, 6};
    for (int i = 0; i < 5; i++)
    begin
      wreg(REG_CTRL, ctl[i]);
      wr(8'h3, 3'h0, rs, sp, lt);
      chk(sp, esp[i]);
      chk(lt, 1 + (i != 0));
    end
  endtask

  // write fifo fills while the slave stalls, then drains
  task automatic t_fifo;
    logic [1:0] rs;
    logic [31:0] d;
    int sp, lt, n;
    wreg(REG_CTRL, 32'h33);
    stall <= 1'b1;
    fork
      wr(8'h13, 3'h0, rs, sp, lt);
      begin
        repeat (30) @(posedge clock);
        rreg(REG_STAT, d);
        chk(d & 32'h00ff_ffff, 32'h1012);
        @(negedge clock);
        chk(si_w_ready, 32'h0);
        @(posedge clock);
        stall <= 1'b0;
      end
    join
    chk(last_w, 32'hb3);
    rda(8'h3, 3'h0, rs, n);
    chk({rs, n[7:0]}, {RESP_OKAY, 8'h4});
    rreg(REG_STAT, d);
    chk({d[29:0], rs}, {30'h0200_0011, RESP_OKAY});
  endtask

  task automatic finish_test;
    if (fails == 0 && checks_done > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // watchdog
  initial
  begin
    #50us;
    fails++;
    finish_test;
  end

  // main sequence
  initial
  begin
    {nrst, reg_wr, reg_rd, stall, si_aw_valid, si_w_valid} = '0;
    {si_ar_valid, reg_addr, reg_wdata, si_aw, si_w, si_ar} = '0;
    fails = 0;
    checks_done = 0;
    repeat (3) @(posedge clock);
    nrst <= 1'b1;
    t_regs;
    t_secure;
    quiet(32'h0555_5502, 1'b1);
    quiet(32'h0555_5501, 1'b0);
    t_slice;
    t_fifo;
    finish_test;
  end
endmodule
